// File: verilog/ccr_control_regs.sv
// Purpose: Control register bank of the clock recovery receiver with its parallel bit ordering.
// Assumes: One clock sys_clk at 100 MHz; synchronous active-low reset; writes over two-wire port.
// Notes: Registers are write only; their fields drive the analog controls as plain outputs.
// How it works
// (RL1) Degrade threshold select and degrade enable bits.
// (RL2) Bypass register: recovery off, driver power-downs.
// (RL3) One-then-zero on start bit runs pattern mode.
// (RL4) Receive reversal picks bit 0 or 7.
// (RL5) Transmit reversal picks bit 0 or 7 last.
// (RL6) Subharmonic enable plus five-bit ratio field.
// (RL7) Range, single rate, acquisition mode select bits.
// (RL8) All control registers reset to zero.
// (RL9) Registers hold until rewritten or reset.
`timescale 1ns/100ps
`include "ccr_defs.svh"
module ccr_control_regs (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic signal_degrade_threshold_sel,
	output logic signal_degrade_enable,
	output logic los_active_low,
	output logic serial_clock_buffer_enable,
	output logic recovery_disable,
	output logic lvds_power_down,
	output logic cml_power_down,
	output logic pattern_start,
	output logic [2:0] pattern_run_mode,
	output logic subharmonic_lock_mode,
	output logic [4:0] subharmonic_ratio,
	output logic reference_timed_only_mode,
	output logic single_rate,
	output logic limited_range,
	output logic holdover_mode_a,
	output logic holdover_mode_b,
	output logic [1:0] recovered_data_path,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	output logic [7:0] receive_parallel_word,
	output logic rx_word_valid,
	input wire logic [7:0] transmit_parallel_word,
	input wire logic tx_load,
	input wire logic tx_shift,
	output logic tx_bit,
	output logic tx_busy
);
	ccr_wr_if wr_bus (); // Writes from the serial front end.

	logic [7:0] signal_detect_config; // Degrade and buffer controls.
	logic [7:0] recovery_bypass_pattern_control; // Bypass, power-down and pattern controls.
	logic [7:0] parallel_bus_alignment; // Bus reversal controls.
	logic [7:0] subharmonic_lock_config; // Subharmonic lock controls.
	logic [7:0] rate_select_mode; // Rate and acquisition controls.
	logic [7:0] recovery_path_mode; // Recovered data routing.
	logic [7:0] rx_shift; // Receive word being assembled.
	logic [3:0] rx_cnt; // Received bits in this word.
	logic [7:0] tx_shift_reg; // Transmit word being sent.
	logic [7:0] tx_word_hold; // Copy of the loaded transmit word.
	logic [3:0] tx_cnt; // Transmit bits still to send.
	logic tx_rev_q; // Transmit order latched at load.
	logic [7:0] next_rx_shift; // Receive word with the new bit placed.

	// Serial front end feeding the register writes.
	ccr_i2c_front front (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.scl(scl),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.wr(wr_bus.source)
	);

	// Register store: reset to zero, update only on a write to the matching offset.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			signal_detect_config <= `CCR_RESET_VALUE; // RL8
			recovery_bypass_pattern_control <= `CCR_RESET_VALUE; // RL8
			parallel_bus_alignment <= `CCR_RESET_VALUE; // RL8
			subharmonic_lock_config <= `CCR_RESET_VALUE; // RL8
			rate_select_mode <= `CCR_RESET_VALUE; // RL8
			recovery_path_mode <= `CCR_RESET_VALUE; // RL8
		end else if (wr_bus.wr_valid) begin
			// Reserved bits are forced to zero; unknown offsets are ignored.
			unique case (wr_bus.wr_addr)
				`CCR_OFF_SIGNAL_DETECT: signal_detect_config <= wr_bus.wr_data & `CCR_MASK_SIGNAL_DETECT; // RL9
				`CCR_OFF_BYPASS_PATTERN: recovery_bypass_pattern_control <= wr_bus.wr_data & `CCR_MASK_BYPASS_PATTERN; // RL9
				`CCR_OFF_BUS_ALIGN: parallel_bus_alignment <= wr_bus.wr_data & `CCR_MASK_BUS_ALIGN; // RL9
				`CCR_OFF_SUBHARMONIC: subharmonic_lock_config <= wr_bus.wr_data & `CCR_MASK_SUBHARMONIC; // RL9
				`CCR_OFF_RATE_SELECT: rate_select_mode <= wr_bus.wr_data & `CCR_MASK_RATE_SELECT; // RL9
				`CCR_OFF_PATH_MODE: recovery_path_mode <= wr_bus.wr_data & `CCR_MASK_PATH_MODE; // RL9
				default: begin
				end
			endcase
		end
	end

	// Zero selects the fixed 9 mV degrade threshold, one selects 1.9 times the loss threshold.
	assign signal_degrade_threshold_sel = signal_detect_config[`CCR_SD_THRESH_BIT]; // RL1
	assign signal_degrade_enable = signal_detect_config[`CCR_SD_ENABLE_BIT]; // RL1
	assign los_active_low = signal_detect_config[`CCR_LOS_POLARITY_BIT];
	assign serial_clock_buffer_enable = signal_detect_config[`CCR_SERIAL_CLOCK_BUFFER_BUF_BIT];
	// Bypass and driver power-down controls; zero keeps normal operation.
	assign recovery_disable = recovery_bypass_pattern_control[`CCR_CDR_DISABLE_BIT]; // RL2
	assign lvds_power_down = recovery_bypass_pattern_control[`CCR_LVDS_PD_BIT]; // RL2
	assign cml_power_down = recovery_bypass_pattern_control[`CCR_CML_PD_BIT]; // RL2
	// Subharmonic lock enable and ratio field.
	assign subharmonic_lock_mode = subharmonic_lock_config[`CCR_SUBHARM_EN_BIT]; // RL6
	assign subharmonic_ratio = subharmonic_lock_config[6:2]; // RL6
	// Rate and acquisition selection.
	assign reference_timed_only_mode = rate_select_mode[`CCR_ACQ_MODE_BIT]; // RL7
	assign single_rate = rate_select_mode[`CCR_SINGLE_RATE_BIT]; // RL7
	assign limited_range = rate_select_mode[`CCR_LIMITED_RANGE_BIT]; // RL7
	assign holdover_mode_a = rate_select_mode[`CCR_HOLDOVER_A_BIT];
	assign holdover_mode_b = rate_select_mode[`CCR_HOLDOVER_B_BIT];
	assign recovered_data_path = recovery_path_mode[1:0];

	// Pattern engine launch: a write clearing the start bit after it was set.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pattern_start <= 1'b0;
			pattern_run_mode <= 3'h0;
		end else begin
			pattern_start <= 1'b0;
			if (wr_bus.wr_valid && wr_bus.wr_addr == `CCR_OFF_BYPASS_PATTERN
				&& recovery_bypass_pattern_control[`CCR_PATTERN_START_BIT]
				&& !wr_bus.wr_data[`CCR_PATTERN_START_BIT]) begin
				pattern_start <= 1'b1; // RL3
				pattern_run_mode <= wr_bus.wr_data[2:0]; // RL3
			end
		end
	end

	// Newest bit goes to bit 0 normally, to bit 7 when reversed.
	always_comb begin
		if (parallel_bus_alignment[`CCR_RX_REVERSE_BIT]) begin
			next_rx_shift = {rx_bit, rx_shift[7:1]}; // RL4
		end else begin
			next_rx_shift = {rx_shift[6:0], rx_bit}; // RL4
		end
	end

	// Receive word assembly; the word is presented after its eighth bit.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rx_shift <= 8'h00;
			rx_cnt <= 4'h0;
			receive_parallel_word <= 8'h00;
			rx_word_valid <= 1'b0;
		end else begin
			rx_word_valid <= 1'b0;
			if (rx_bit_valid) begin
				rx_shift <= next_rx_shift;
				if (rx_cnt == `CCR_WORD_BITS - 4'h1) begin
					rx_cnt <= 4'h0;
					receive_parallel_word <= next_rx_shift; // RL4
					rx_word_valid <= 1'b1;
				end else begin
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end

	// Transmit serializer; the order is latched at load so a rewrite cannot split a word.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tx_shift_reg <= 8'h00;
			tx_word_hold <= 8'h00;
			tx_cnt <= 4'h0;
			tx_rev_q <= 1'b0;
			tx_bit <= 1'b0;
		end else if (tx_load && tx_cnt == 4'h0) begin
			tx_shift_reg <= transmit_parallel_word;
			tx_word_hold <= transmit_parallel_word;
			tx_rev_q <= parallel_bus_alignment[`CCR_TX_REVERSE_BIT];
			tx_cnt <= `CCR_WORD_BITS;
		end else if (tx_shift && tx_cnt != 4'h0) begin
			// Normal order sends bit 7 first so bit 0 is last; reversed sends bit 7 last.
			if (tx_rev_q) begin
				tx_bit <= tx_shift_reg[0]; // RL5
				tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
			end else begin
				tx_bit <= tx_shift_reg[7]; // RL5
				tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
			end
			tx_cnt <= tx_cnt - 4'h1;
		end
	end

	// Busy while bits of the loaded word remain; a load is refused then.
	assign tx_busy = (tx_cnt != 4'h0);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	reset_zero_a: assert property ($rose(reset_n) |-> signal_detect_config == 8'h00 && rate_select_mode == 8'h00
		&& recovery_bypass_pattern_control == 8'h00 && subharmonic_lock_config == 8'h00) // RL8
		else $error("control register not zero after reset");
	hold_value_a: assert property (!wr_bus.wr_valid |=> $stable(signal_detect_config) && $stable(parallel_bus_alignment)
		&& $stable(recovery_bypass_pattern_control)) // RL9
		else $error("control register changed without a write");
	degrade_write_a: assert property (wr_bus.wr_valid && wr_bus.wr_addr == `CCR_OFF_SIGNAL_DETECT
		|=> signal_degrade_threshold_sel == $past(wr_bus.wr_data[5]) && signal_degrade_enable == $past(wr_bus.wr_data[4])) // RL1
		else $error("degrade controls do not follow the write");
	bypass_write_a: assert property (wr_bus.wr_valid && wr_bus.wr_addr == `CCR_OFF_BYPASS_PATTERN
		|=> {recovery_disable, lvds_power_down, cml_power_down} == $past(wr_bus.wr_data[7:5])) // RL2
		else $error("bypass controls do not follow the write");
	pattern_cause_a: assert property (pattern_start |-> $past(wr_bus.wr_valid) && !$past(wr_bus.wr_data[3])
		&& pattern_run_mode == $past(wr_bus.wr_data[2:0]) && !recovery_bypass_pattern_control[3]) // RL3
		else $error("pattern start without a one-then-zero write");
	rx_order_a: assert property (rx_word_valid |-> (($past(parallel_bus_alignment[2]) ? receive_parallel_word[7]
		: receive_parallel_word[0]) == $past(rx_bit))) // RL4
		else $error("last received bit in wrong position");
	tx_order_a: assert property (tx_shift && tx_cnt == 4'h1 |=> tx_bit == (tx_rev_q ? tx_word_hold[7] : tx_word_hold[0])) // RL5
		else $error("wrong bit sent last");
	subharm_write_a: assert property (wr_bus.wr_valid && wr_bus.wr_addr == `CCR_OFF_SUBHARMONIC
		|=> subharmonic_lock_mode == $past(wr_bus.wr_data[7]) && subharmonic_ratio == $past(wr_bus.wr_data[6:2])) // RL6
		else $error("subharmonic controls do not follow the write");
	rate_write_a: assert property (wr_bus.wr_valid && wr_bus.wr_addr == `CCR_OFF_RATE_SELECT
		|=> {reference_timed_only_mode, single_rate, limited_range} == $past(wr_bus.wr_data[5:3])) // RL7
		else $error("rate controls do not follow the write");

	pattern_cov_c: cover property (pattern_start && pattern_run_mode == 3'h1);
	rx_rev_cov_c: cover property (rx_word_valid && parallel_bus_alignment[2]);
	tx_done_cov_c: cover property (tx_shift && tx_cnt == 4'h1 && tx_rev_q);
	subharm_cov_c: cover property (subharmonic_lock_mode && subharmonic_ratio == 5'h1F);
endmodule

// File: verilog/ccr_defs.svh
// Purpose: Offsets, field positions, masks and reset values of the control register set.
// Assumes: Registers are eight bits wide and reached over the two-wire serial port.
// Notes: Included by its bare name; holds definitions only.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Seven-bit two-wire slave address; the value is arbitrary.
`define CCR_DEV_ADDR 7'h5A

// Register offsets on the two-wire port.
`define CCR_OFF_SIGNAL_DETECT 8'h11
`define CCR_OFF_BYPASS_PATTERN 8'h22
`define CCR_OFF_BUS_ALIGN 8'h27
`define CCR_OFF_SUBHARMONIC 8'h0D
`define CCR_OFF_RATE_SELECT 8'h34
`define CCR_OFF_PATH_MODE 8'h3B

// Writable-bit masks; reserved bits are stored as zero.
`define CCR_MASK_SIGNAL_DETECT 8'h36
`define CCR_MASK_BYPASS_PATTERN 8'hEF
`define CCR_MASK_BUS_ALIGN 8'hFE
`define CCR_MASK_SUBHARMONIC 8'hFC
`define CCR_MASK_RATE_SELECT 8'h3E
`define CCR_MASK_PATH_MODE 8'h03

// Value of every control register after reset.
`define CCR_RESET_VALUE 8'h00

// Field positions.
`define CCR_SD_THRESH_BIT 5
`define CCR_SD_ENABLE_BIT 4
`define CCR_LOS_POLARITY_BIT 2
`define CCR_SERIAL_CLOCK_BUFFER_BUF_BIT 1
`define CCR_CDR_DISABLE_BIT 7
`define CCR_LVDS_PD_BIT 6
`define CCR_CML_PD_BIT 5
`define CCR_PATTERN_START_BIT 3
`define CCR_RX_REVERSE_BIT 2
`define CCR_TX_REVERSE_BIT 1
`define CCR_SUBHARM_EN_BIT 7
`define CCR_ACQ_MODE_BIT 5
`define CCR_SINGLE_RATE_BIT 4
`define CCR_LIMITED_RANGE_BIT 3
`define CCR_HOLDOVER_A_BIT 2
`define CCR_HOLDOVER_B_BIT 1

// Bits in one parallel word, as a shift count.
`define CCR_WORD_BITS 4'h8

`endif

// File: verilog/ccr_pkg.sv
// Purpose: Types shared by the control register set.
// Assumes: Used with ccr_defs.svh.
// Notes: Nothing is imported; users write ccr_pkg::name.
package ccr_pkg;

	// States of the two-wire receive sequencer.
	typedef enum logic [2:0] {
		CCR_IDLE = 3'b000,
		CCR_ADDR = 3'b001,
		CCR_ACK_ADDR = 3'b010,
		CCR_SUB = 3'b011,
		CCR_ACK_SUB = 3'b100,
		CCR_DATA = 3'b101,
		CCR_ACK_DATA = 3'b110
	} ccr_i2c_state_e;

endpackage

// File: verilog/ccr_wr_if.sv
// Purpose: Carries register writes from the serial front end to the register bank.
// Assumes: One clock, sys_clk.
// Notes: wr_valid is a one-cycle pulse.
`timescale 1ns/100ps
interface ccr_wr_if;
	logic wr_valid; // One-cycle write strobe.
	logic [7:0] wr_addr; // Register offset.
	logic [7:0] wr_data; // Byte to store.

	modport source (output wr_valid, output wr_addr, output wr_data);
	modport sink (input wr_valid, input wr_addr, input wr_data);
endinterface

// File: verilog/ccr_i2c_front.sv
// Purpose: Two-wire slave that receives register writes and acknowledges them.
// Assumes: scl and sda_in are synchronous to sys_clk and sampled with margin.
// Notes: Reads are not served; a read address is not acknowledged.
`timescale 1ns/100ps
`include "ccr_defs.svh"
module ccr_i2c_front (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	ccr_wr_if.source wr
);
	ccr_pkg::ccr_i2c_state_e state; // Sequencer state.
	logic scl_q; // Previous clock line level.
	logic sda_q; // Previous data line level.
	logic [3:0] bit_cnt; // Bits taken in this byte.
	logic [7:0] shift; // Byte being received.
	logic [7:0] pointer; // Register offset of the next data byte.
	logic start_cond; // Data falls while clock high.
	logic stop_cond; // Data rises while clock high.
	logic scl_rise; // Clock line rising.
	logic scl_fall; // Clock line falling.

	assign start_cond = scl && scl_q && sda_q && !sda_in;
	assign stop_cond = scl && scl_q && !sda_q && sda_in;
	assign scl_rise = scl && !scl_q;
	assign scl_fall = !scl && scl_q;
	// The pin is only ever pulled low; the enable decides.
	assign sda_out = 1'b0;

	// Line history for edge and condition detection.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
		end
	end

	// Drive the acknowledge low during the acknowledge slot of every accepted byte.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sda_oe_n <= 1'b1;
		end else begin
			// Only the three acknowledge states pull the line; idle must leave it to the pull-up.
			sda_oe_n <= !(state == ccr_pkg::CCR_ACK_ADDR || state == ccr_pkg::CCR_ACK_SUB
				|| state == ccr_pkg::CCR_ACK_DATA);
		end
	end

	// Byte sequencer: address, register offset, then data bytes with auto-increment.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= ccr_pkg::CCR_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			pointer <= 8'h00;
			wr.wr_valid <= 1'b0;
			wr.wr_addr <= 8'h00;
			wr.wr_data <= 8'h00;
		end else begin
			wr.wr_valid <= 1'b0;
			if (start_cond) begin
				// A start, repeated or not, restarts the address phase.
				state <= ccr_pkg::CCR_ADDR;
				bit_cnt <= 4'h0;
			end else if (stop_cond) begin
				state <= ccr_pkg::CCR_IDLE;
			end else if (scl_rise && bit_cnt != `CCR_WORD_BITS) begin
				// Shift in one bit, most significant first.
				shift <= {shift[6:0], sda_in};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_fall) begin
				unique case (state)
					ccr_pkg::CCR_IDLE: begin
						state <= ccr_pkg::CCR_IDLE;
					end
					ccr_pkg::CCR_ADDR: begin
						if (bit_cnt == `CCR_WORD_BITS) begin
							// Acknowledge only our address with a write direction.
							state <= (shift == {`CCR_DEV_ADDR, 1'b0}) ? ccr_pkg::CCR_ACK_ADDR : ccr_pkg::CCR_IDLE;
						end
					end
					ccr_pkg::CCR_SUB: begin
						if (bit_cnt == `CCR_WORD_BITS) begin
							pointer <= shift;
							state <= ccr_pkg::CCR_ACK_SUB;
						end
					end
					ccr_pkg::CCR_DATA: begin
						if (bit_cnt == `CCR_WORD_BITS) begin
							// Hand the byte over as the acknowledge starts.
							wr.wr_valid <= 1'b1;
							wr.wr_addr <= pointer;
							wr.wr_data <= shift;
							state <= ccr_pkg::CCR_ACK_DATA;
						end
					end
					ccr_pkg::CCR_ACK_ADDR: begin
						state <= ccr_pkg::CCR_SUB;
						bit_cnt <= 4'h0;
					end
					ccr_pkg::CCR_ACK_SUB: begin
						state <= ccr_pkg::CCR_DATA;
						bit_cnt <= 4'h0;
					end
					ccr_pkg::CCR_ACK_DATA: begin
						state <= ccr_pkg::CCR_DATA;
						pointer <= pointer + 8'h01;
						bit_cnt <= 4'h0;
					end
					default: begin
						state <= ccr_pkg::CCR_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench for the control register bank and its parallel bit ordering.
// Assumes: Registers are written over the two-wire port only; one 100 MHz clock.
// Notes: Drivers note expected results in queues; a monitor pops a note when a result shows.
`timescale 1ns/100ps
`include "ccr_defs.svh"
module tb;
	// Design inputs, plus the bench's own open-drain drive of the data wire.
	logic sys_clk = 1'b0, reset_n = 1'b0, scl = 1'b1, sda_drv = 1'b1, rx_bit = 1'b0, rx_bit_valid = 1'b0;
	logic [7:0] transmit_parallel_word = 8'h00;
	logic tx_load = 1'b0, tx_shift = 1'b0;
	wire logic sda_in;
	// Design outputs.
	logic sda_out, sda_oe_n, signal_degrade_threshold_sel, signal_degrade_enable, los_active_low;
	logic serial_clock_buffer_enable, recovery_disable, lvds_power_down, cml_power_down, pattern_start;
	logic subharmonic_lock_mode, reference_timed_only_mode, single_rate, limited_range;
	logic holdover_mode_a, holdover_mode_b, rx_word_valid, tx_bit, tx_busy;
	logic [2:0] pattern_run_mode;
	logic [4:0] subharmonic_ratio;
	logic [1:0] recovered_data_path;
	logic [7:0] receive_parallel_word;
	// Counters, seed, register table, shadow copies and expectation queues.
	int errors = 0, checks_done = 0, seed = 16076;
	logic [7:0] offs [0:5] = '{`CCR_OFF_SIGNAL_DETECT, `CCR_OFF_BYPASS_PATTERN, `CCR_OFF_BUS_ALIGN,
		`CCR_OFF_SUBHARMONIC, `CCR_OFF_RATE_SELECT, `CCR_OFF_PATH_MODE};
	logic [7:0] masks [0:5] = '{`CCR_MASK_SIGNAL_DETECT, `CCR_MASK_BYPASS_PATTERN, `CCR_MASK_BUS_ALIGN,
		`CCR_MASK_SUBHARMONIC, `CCR_MASK_RATE_SELECT, `CCR_MASK_PATH_MODE};
	logic [7:0] shadow [0:5] = '{default: 8'h00};
	logic [19:0] reg_q [$];
	logic [7:0] rx_q [$];
	logic [2:0] pat_q [$];
	logic tx_q [$];
	logic reg_req = 1'b0, pat_d = 1'b0, shift_d = 1'b0;
	// All stored control fields seen at the ports, in one vector.
	wire logic [19:0] reg_vec = {signal_degrade_threshold_sel, signal_degrade_enable, los_active_low,
		serial_clock_buffer_enable, recovery_disable, lvds_power_down, cml_power_down, subharmonic_lock_mode,
		subharmonic_ratio, reference_timed_only_mode, single_rate, limited_range, holdover_mode_a,
		holdover_mode_b, recovered_data_path};

	// The device pulls the wire low while its enable is low; otherwise the bench's own drive sets it.
	assign sda_in = sda_drv & (sda_oe_n | sda_out);
	// Free-running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;
	ccr_control_regs i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .signal_degrade_threshold_sel(signal_degrade_threshold_sel),
		.signal_degrade_enable(signal_degrade_enable), .los_active_low(los_active_low),
		.serial_clock_buffer_enable(serial_clock_buffer_enable), .recovery_disable(recovery_disable),
		.lvds_power_down(lvds_power_down), .cml_power_down(cml_power_down), .pattern_start(pattern_start),
		.pattern_run_mode(pattern_run_mode), .subharmonic_lock_mode(subharmonic_lock_mode),
		.subharmonic_ratio(subharmonic_ratio), .reference_timed_only_mode(reference_timed_only_mode),
		.single_rate(single_rate), .limited_range(limited_range), .holdover_mode_a(holdover_mode_a),
		.holdover_mode_b(holdover_mode_b), .recovered_data_path(recovered_data_path), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .receive_parallel_word(receive_parallel_word),
		.rx_word_valid(rx_word_valid), .transmit_parallel_word(transmit_parallel_word),
		.tx_load(tx_load), .tx_shift(tx_shift), .tx_bit(tx_bit), .tx_busy(tx_busy)
	);

	// Builds the expected field vector from the shadow registers.
	function automatic logic [19:0] model_vec();
		return {shadow[0][5], shadow[0][4], shadow[0][2], shadow[0][1], shadow[1][7:5], shadow[3][7:2],
			shadow[4][5:1], shadow[5][1:0]};
	endfunction
	// Mirrors the bit order of a byte.
	function automatic logic [7:0] flip(input logic [7:0] v);
		int i;
		for (i = 0; i < 8; i++) flip[i] = v[7-i];
	endfunction
	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Waits a number of rising edges.
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Prints the end of one test.
	task automatic done_t(input string n);
		$display("test %s done, errors so far %0d", n, errors);
	endtask
	// Notes the expected fields and asks the monitor to compare them.
	task automatic note_regs();
		reg_q.push_back(model_vec());
		reg_req <= 1'b1;
		tick(1);
		reg_req <= 1'b0;
		tick(1);
	endtask

	// One wire bit: data changes while the clock line is low, each phase four cycles or more.
	task automatic bitw(input logic v);
		sda_drv <= v;
		tick(4);
		scl <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(1);
	endtask
	// Start condition: data falls while the clock line is high.
	task automatic start_c();
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	// Stop condition: data rises while the clock line is high.
	task automatic stop_c();
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b1;
		tick(4);
	endtask
	// Sends a byte MSB first and checks the acknowledge slot.
	task automatic send(input logic [7:0] b, input logic ack);
		int i;
		for (i = 7; i >= 0; i--) bitw(b[i]);
		sda_drv <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(2);
		chk("acknowledge enable", {19'h0, !ack}, {19'h0, sda_oe_n});
		tick(2);
		scl <= 1'b0;
		tick(1);
	endtask
	// Full register write, shadow update and field check.
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		int i;
		// The launch pulse shows during the data acknowledge, so its note must be queued first.
		if (off === `CCR_OFF_BYPASS_PATTERN && shadow[1][`CCR_PATTERN_START_BIT] && !d[`CCR_PATTERN_START_BIT])
			pat_q.push_back(d[2:0]);
		start_c();
		send({`CCR_DEV_ADDR, 1'b0}, 1'b1);
		send(off, 1'b1);
		send(d, 1'b1);
		stop_c();
		for (i = 0; i < 6; i++) if (offs[i] === off) shadow[i] = d & masks[i];
		note_regs();
	endtask
	// Resets the design and checks the acknowledge enable, busy and the stored fields for their idle state.
	task automatic do_reset(input int n);
		int i;
		reset_n <= 1'b0;
		tick(n);
		reset_n <= 1'b1;
		for (i = 0; i < 6; i++) shadow[i] = `CCR_RESET_VALUE;
		tick(1);
		chk("idle enable and busy", 20'h1, {18'h0, tx_busy, sda_oe_n});
		note_regs();
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		if (reg_q.size() + rx_q.size() + pat_q.size() + tx_q.size() != 0) begin
			errors++;
			$display("ERROR pending notes expected 0 seen %0d", reg_q.size() + rx_q.size() + pat_q.size() + tx_q.size());
		end
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Monitor: each result that appears takes the oldest note of its kind.
	always @(posedge sys_clk) begin
		pat_d <= pattern_start;
		shift_d <= tx_shift;
		if (reg_req) chk("register fields", reg_q.size() ? reg_q.pop_front() : 20'hx, reg_vec);
		if (pat_d) chk("pattern mode", pat_q.size() ? pat_q.pop_front() : 20'hx, pattern_run_mode);
		if (rx_word_valid) chk("receive word", rx_q.size() ? rx_q.pop_front() : 20'hx, receive_parallel_word);
		if (shift_d) chk("transmit bit", tx_q.size() ? tx_q.pop_front() : 20'hx, tx_bit);
	end

	// Watchdog: the tests take about 22000 cycles.
	initial begin
		tick(60000);
		errors++;
		$display("ERROR watchdog expected done seen hang");
		wrap_up();
	end

	// Main sequence.
	initial begin
		logic [7:0] w;
		int i, k;
		tick(20);
		do_reset(1);
		done_t("reset");
		for (i = 0; i < 6; i++) wr(offs[i], 8'hFF);
		wr(8'h40, 8'hFF);
		done_t("reserved and unlisted");
		for (k = 0; k < 2; k++) begin
			start_c();
			send(k ? {`CCR_DEV_ADDR, 1'b1} : {`CCR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
			send(offs[0], 1'b0);
			send(8'h00, 1'b0);
			stop_c();
			note_regs();
		end
		done_t("refused address");
		for (k = 0; k < 8; k++) for (i = 0; i < 6; i++) wr(offs[i], (8'h01 << k) & masks[i]);
		for (k = 0; k < 10; k++) begin
			i = $unsigned($random(seed)) % 6;
			w = $random(seed) & masks[i];
			if (i == 1) w[2:0] = {2'b00, w[0]};
			wr(offs[i], w);
		end
		done_t("fields");
		for (k = 0; k < 3; k++) begin
			wr(`CCR_OFF_BYPASS_PATTERN, 8'h08 | k);
			wr(`CCR_OFF_BYPASS_PATTERN, k);
		end
		done_t("pattern");
		for (k = 0; k < 2; k++) begin
			wr(`CCR_OFF_BUS_ALIGN, k << `CCR_RX_REVERSE_BIT);
			repeat (2) begin
				w = $random(seed);
				rx_q.push_back(k ? flip(w) : w);
				for (i = 0; i < 8; i++) begin
					rx_bit <= w[7-i];
					rx_bit_valid <= 1'b1;
					tick(1);
				end
			end
			rx_bit_valid <= 1'b0;
			tick(3);
		end
		done_t("receive order");
		for (k = 0; k < 2; k++) begin
			wr(`CCR_OFF_BUS_ALIGN, k << `CCR_TX_REVERSE_BIT);
			w = $random(seed);
			for (i = 0; i < 8; i++) tx_q.push_back(k ? w[i] : w[7-i]);
			transmit_parallel_word <= w;
			tx_load <= 1'b1;
			tick(1);
			tx_load <= 1'b0;
			tick(1);
			chk("busy after load", 20'h1, {19'h0, tx_busy});
			tx_shift <= 1'b1;
			tick(3);
			transmit_parallel_word <= ~w;
			tx_load <= 1'b1;
			tick(1);
			tx_load <= 1'b0;
			tick(4);
			tx_shift <= 1'b0;
			tick(1);
			chk("busy after last bit", 20'h0, {19'h0, tx_busy});
			tick(2);
		end
		done_t("transmit order");
		for (i = 0; i < 6; i++) wr(offs[i], masks[i]);
		do_reset(2);
		done_t("second reset");
		tick(4);
		wrap_up();
	end
endmodule
